// ### design/phase_if.sv
`timescale 1ns/1ps
// phase timer handshake between sequencer and timer
interface phase_if;
  logic [31:0] load_len;
  logic        load;
  logic        done;
  modport seq   (output load_len, output load, input done);
  modport timer (input load_len, input load, output done);
endinterface

// ### design/phase_timer.sv
`timescale 1ns/1ps
module phase_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // sequencer side
  phase_if.timer    tp
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;
  tmr_t cur, next_cur;

  // count down loaded length; a reload wins over the count
  always_comb begin
    next_cur = cur;
    if (tp.load) begin
      next_cur.cnt = W'(tp.load_len);
    end else if (cur.cnt != '0) begin
      next_cur.cnt = cur.cnt - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) cur <= '0;
    else cur <= next_cur;
  end

  // done in the last counted cycle, so a phase of length n lasts n cycles
  assign tp.done = (cur.cnt == W'(1));
endmodule // phase_timer

// ### design/touch_pkg.sv
package touch_pkg;
  // timing figures as printed
  localparam int CLK_MHZ                 = 100;
  localparam int HEALTH_PULSE_WIDTH_NS   = 15000;
  localparam int CHARGE_PHASE_TIME_NS    = 3050;
  localparam int TRANSFER_PHASE_TIME_NS  = 9000;
  localparam int FAST_GAP_TIME_US        = 1200;
  localparam int SLEEP_GAP_TIME_US       = 80000;
  localparam int BURST_SPAN_US           = 2450;
  localparam int STARTUP_TIME_US         = 100000;
  localparam int DITHER_PERMILLE         = 75;
  // derived cycle counts
  localparam int HEALTH_CYC   = HEALTH_PULSE_WIDTH_NS * CLK_MHZ / 1000;
  localparam int CHARGE_CYC   = CHARGE_PHASE_TIME_NS * CLK_MHZ / 1000;
  localparam int TRANSFER_CYC = TRANSFER_PHASE_TIME_NS * CLK_MHZ / 1000;
  localparam int FAST_GAP_CYC = FAST_GAP_TIME_US * CLK_MHZ;
  localparam int SLEEP_GAP_CYC = SLEEP_GAP_TIME_US * CLK_MHZ;
  localparam int BURST_CYC    = BURST_SPAN_US * CLK_MHZ;
  localparam int STARTUP_CYC  = STARTUP_TIME_US * CLK_MHZ;
  localparam int CONSENSUS    = 4;
  localparam int CNT_W        = 32;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef enum logic [2:0] {
    ST_STARTUP = 3'h0,
    ST_HEALTH  = 3'h1,
    ST_CHARGE  = 3'h3,
    ST_XFER    = 3'h2,
    ST_GAP     = 3'h6
  } seq_state_t;
endpackage

// ### design/touch_sense_seq.sv
`timescale 1ns/1ps
// Operation
// - Before every burst the detect pin is released to high impedance for about 15 us.
// - The health pulse appears in fast and sleepy modes alike.
// - In fast mode the gap between bursts is 1.2 ms.
// - In sleepy mode the gap between bursts is 80 ms, and 1.2 ms while a touch is pending.
// - Charge phases last 3.05 us and transfer phases 9.0 us, dithered by 7.5 percent.
// - A whole burst lasts at least 2.45 ms and ends with the first transfer phase that completes after that.
// - Detect is high while detection lasts and drops at its end or on max on-duration expiry; expiry is only sampled in the gap and at burst end.
// - Detect rises only after four successive over-threshold results; a miss clears the count.
// - Trigger pin high gives fast mode, low gives sleepy mode.
module touch_sense_seq #(
  parameter int STARTUP_CYC   = touch_pkg::STARTUP_CYC,
  parameter int SLEEP_GAP_CYC = touch_pkg::SLEEP_GAP_CYC,
  parameter int FAST_GAP_CYC  = touch_pkg::FAST_GAP_CYC,
  parameter int BURST_CYC     = touch_pkg::BURST_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // mode pin and analog front end result
  input  wire logic trigger_pin,
  input  wire logic burst_over_thresh,
  input  wire logic max_on_expired,
  // detect pin, two signals
  output logic      detect_out,
  output logic      detect_oe,
  // measurement status
  output logic      burst_active,
  output logic      charge_active,
  output logic      sleepy_run_mode,
  output logic      burst_done
);
  typedef struct packed {
    touch_pkg::seq_state_t st;
    logic [31:0]           burst_cnt;
    logic [15:0]           lfsr;
    logic [2:0]            consensus;
    logic                  detect;
    logic                  oe;
    logic                  bact;
    logic                  cact;
    logic                  sleepy;
    logic                  bdone;
    logic [15:0]           hz_cnt;
  } seq_s_t;
  seq_s_t cur, next_cur;

  // power-on state: pin driven low during start-up, host ignores it
  localparam seq_s_t RST_STATE = '{
    st:        touch_pkg::ST_STARTUP,
    burst_cnt: 32'h0,
    lfsr:      touch_pkg::LFSR_SEED,
    consensus: 3'h0,
    detect:    1'b0,
    oe:        1'b1,
    bact:      1'b0,
    cact:      1'b0,
    sleepy:    1'b0,
    bdone:     1'b0,
    hz_cnt:    16'h0
  };

  phase_if tp();
  phase_timer #(.W(touch_pkg::CNT_W)) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tp      (tp)
  );

  // dithered phase length, +-7.5 percent from lfsr bits
  function automatic logic [31:0] dither(input int base, input logic [15:0] r);
    int span;
    int off;
    span = base * touch_pkg::DITHER_PERMILLE / 1000;
    off = int'(r[7:0]) % (2 * span + 1) - span;
    return 32'(base + off);
  endfunction

  logic        ld;
  logic [31:0] ld_len;
  assign tp.load = ld;
  assign tp.load_len = ld_len;

  // sequencer next state
  always_comb begin
    next_cur = cur;
    ld = 1'b0;
    ld_len = '0;
    next_cur.bdone = 1'b0;
    next_cur.lfsr = {cur.lfsr[14:0], cur.lfsr[15] ^ cur.lfsr[13] ^ cur.lfsr[12] ^ cur.lfsr[10]};
    next_cur.hz_cnt = cur.oe ? 16'h0 : cur.hz_cnt + 16'h1; // release length for checks
    if (cur.bact) next_cur.burst_cnt = cur.burst_cnt + 32'h1;
    unique case (cur.st)
      touch_pkg::ST_STARTUP: begin
        if (cur.burst_cnt == 32'(STARTUP_CYC)) begin
          next_cur.st = touch_pkg::ST_HEALTH;
          next_cur.oe = 1'b0;
          ld = 1'b1;
          ld_len = 32'(touch_pkg::HEALTH_CYC);
        end else begin
          next_cur.burst_cnt = cur.burst_cnt + 32'h1;
        end
      end
      touch_pkg::ST_HEALTH: if (tp.done) begin
        next_cur.oe = 1'b1;
        next_cur.st = touch_pkg::ST_CHARGE;
        next_cur.bact = 1'b1;
        next_cur.cact = 1'b1;
        next_cur.burst_cnt = '0;
        ld = 1'b1;
        ld_len = dither(touch_pkg::CHARGE_CYC, cur.lfsr);
      end
      touch_pkg::ST_CHARGE: if (tp.done) begin
        next_cur.st = touch_pkg::ST_XFER;
        next_cur.cact = 1'b0;
        ld = 1'b1;
        ld_len = dither(touch_pkg::TRANSFER_CYC, cur.lfsr);
      end
      touch_pkg::ST_XFER: if (tp.done) begin
        if (cur.burst_cnt >= 32'(BURST_CYC)) begin
          next_cur.st = touch_pkg::ST_GAP;
          next_cur.bact = 1'b0;
          next_cur.bdone = 1'b1;
          next_cur.sleepy = ~trigger_pin;
          if (!burst_over_thresh || max_on_expired) begin
            next_cur.consensus = '0;
            next_cur.detect = 1'b0;
          end else if (cur.consensus == 3'(touch_pkg::CONSENSUS - 1)) begin
            next_cur.detect = 1'b1;
            next_cur.consensus = 3'(touch_pkg::CONSENSUS - 1);
          end else begin
            next_cur.consensus = cur.consensus + 3'h1;
          end
          ld = 1'b1;
          // sleepy mode runs fast while a touch is pending
          if (!trigger_pin && !(burst_over_thresh && !cur.detect))
            ld_len = 32'(SLEEP_GAP_CYC);
          else
            ld_len = 32'(FAST_GAP_CYC);
        end else begin
          next_cur.st = touch_pkg::ST_CHARGE;
          next_cur.cact = 1'b1;
          ld = 1'b1;
          ld_len = dither(touch_pkg::CHARGE_CYC, cur.lfsr);
        end
      end
      touch_pkg::ST_GAP: begin
        if (max_on_expired) begin
          next_cur.detect = 1'b0;
          next_cur.consensus = '0;
        end
        if (tp.done) begin
          next_cur.st = touch_pkg::ST_HEALTH;
          next_cur.oe = 1'b0;
          ld = 1'b1;
          ld_len = 32'(touch_pkg::HEALTH_CYC);
        end
      end
      default: next_cur.st = touch_pkg::ST_STARTUP;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= RST_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  assign detect_out = cur.detect;
  assign detect_oe = cur.oe;
  assign burst_active = cur.bact;
  assign charge_active = cur.cact;
  assign sleepy_run_mode = cur.sleepy;
  assign burst_done = cur.bdone;

  // health release width, counted in the state struct
  property p_health_width;
    @(posedge clk) disable iff (sys_rst)
      $rose(cur.oe) |-> $past(cur.hz_cnt) == 16'(touch_pkg::HEALTH_CYC - 1);
  endproperty
  a_health_width: assert property (p_health_width) else $error("health width wrong");

  property p_health_before_burst;
    @(posedge clk) disable iff (sys_rst)
      $rose(cur.bact) |-> $past(!cur.oe);
  endproperty
  a_health_before_burst: assert property (p_health_before_burst) else $error("no health");

  property p_no_overlap;
    @(posedge clk) disable iff (sys_rst) cur.cact |-> cur.oe;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("release overlaps charge");

  property p_detect_rise;
    @(posedge clk) disable iff (sys_rst)
      $rose(cur.detect) |-> $past(cur.consensus) == 3'(touch_pkg::CONSENSUS - 1);
  endproperty
  a_detect_rise: assert property (p_detect_rise) else $error("early detect");

  property p_miss_clears;
    @(posedge clk) disable iff (sys_rst)
      (cur.st == touch_pkg::ST_XFER && tp.done && !burst_over_thresh &&
       cur.burst_cnt >= 32'(BURST_CYC)) |=> cur.consensus == 3'h0 && !cur.detect;
  endproperty
  a_miss_clears: assert property (p_miss_clears) else $error("miss not cleared");

  property p_mode;
    @(posedge clk) disable iff (sys_rst)
      $rose(cur.bdone) |-> cur.sleepy == !$past(trigger_pin);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");

  property p_burst_long;
    @(posedge clk) disable iff (sys_rst)
      $fell(cur.bact) |-> $past(cur.burst_cnt) >= 32'(BURST_CYC);
  endproperty
  a_burst_long: assert property (p_burst_long) else $error("burst short");

  property p_startup_quiet;
    @(posedge clk) disable iff (sys_rst)
      cur.st == touch_pkg::ST_STARTUP |-> cur.oe && !cur.detect;
  endproperty
  a_startup_quiet: assert property (p_startup_quiet) else $error("startup drives");

  property p_fast_gap;
    @(posedge clk) disable iff (sys_rst)
      (ld && next_cur.st == touch_pkg::ST_GAP && trigger_pin)
      |-> ld_len == 32'(FAST_GAP_CYC);
  endproperty
  a_fast_gap: assert property (p_fast_gap) else $error("fast gap");

  property p_sleep_gap;
    @(posedge clk) disable iff (sys_rst)
      (ld && next_cur.st == touch_pkg::ST_GAP && !trigger_pin && !burst_over_thresh)
      |-> ld_len == 32'(SLEEP_GAP_CYC);
  endproperty
  a_sleep_gap: assert property (p_sleep_gap) else $error("sleep gap");

  c_burst: cover property (@(posedge clk) $fell(cur.bact));
  c_detect: cover property (@(posedge clk) $rose(cur.detect));
  c_sleepy: cover property (@(posedge clk) $rose(cur.sleepy));
  c_health: cover property (@(posedge clk) $rose(cur.oe));
endmodule // touch_sense_seq

// ### verification/host_probe.sv
`timescale 1ns/1ps
// host side of the detect pin: pull-up load, tally of visible health pulses
module host_probe #(
  parameter int IGNORE_CYC = 100
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // detect pin as the device drives it
  input  wire logic detect_out,
  input  wire logic detect_oe,
  // observed pin level and pulse tally
  output logic      pin_level,
  output int        pulse_count
);
  int   age;
  logic last_level;

  // a released pin floats up through the pull-up
  assign pin_level = detect_oe ? detect_out : 1'b1;

  // start-up level ignored, rising edges counted afterwards
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      age         <= 0;
      last_level  <= 1'b1;
      pulse_count <= 0;
    end else begin
      last_level <= pin_level;
      if (age < IGNORE_CYC) begin
        age <= age + 1;
      end else if (pin_level && !last_level) begin
        pulse_count <= pulse_count + 1;
      end
    end
  end
endmodule // host_probe

// ### verification/touch_sense_seq_tb_top.sv
`timescale 1ns/1ps
module touch_sense_seq_tb_top;
  localparam int STARTUP = 100;
  localparam int SLEEP_GAP = 1000;
  localparam int FAST_GAP = 500;
  localparam int BURST = 1300; // two charge/transfer pairs, keeps the run short
  localparam int CH = touch_pkg::CHARGE_CYC;
  localparam int TR = touch_pkg::TRANSFER_CYC;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trigger_pin = 1'b1;
  logic burst_over_thresh = 1'b0;
  logic max_on_expired = 1'b0;
  logic detect_out, detect_oe, burst_active, charge_active;
  logic sleepy_run_mode, burst_done, pin_level;
  int   pulse_count;
  int   n_fail = 0;
  int   samples_checked = 0;

  touch_sense_seq #(.STARTUP_CYC(STARTUP), .SLEEP_GAP_CYC(SLEEP_GAP),
                    .FAST_GAP_CYC(FAST_GAP), .BURST_CYC(BURST)) dut (
    .clk(clk), .sys_rst(sys_rst), .trigger_pin(trigger_pin),
    .burst_over_thresh(burst_over_thresh), .max_on_expired(max_on_expired),
    .detect_out(detect_out), .detect_oe(detect_oe), .burst_active(burst_active),
    .charge_active(charge_active), .sleepy_run_mode(sleepy_run_mode),
    .burst_done(burst_done));

  host_probe #(.IGNORE_CYC(STARTUP)) host (
    .clk(clk), .sys_rst(sys_rst), .detect_out(detect_out), .detect_oe(detect_oe),
    .pin_level(pin_level), .pulse_count(pulse_count));

  // 100 MHz clock
  always #5 clk = ~clk;

  // selects an observed output by number
  function automatic logic sig(input int k);
    case (k)
      0: return detect_oe;
      1: return burst_active;
      2: return charge_active;
      3: return burst_done;
      default: return detect_out;
    endcase
  endfunction

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic in_range(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // bounded wait on negedges for an output to reach a level
  task automatic wait_for(input int k, input logic v, input int bound);
    for (int i = 0; i < bound && sig(k) !== v; i++) @(negedge clk);
    if (sig(k) !== v) begin
      n_fail++;
      $display("[FAIL] output %0d expected %0b seen %0b", k, v, sig(k));
      give_verdict();
    end
  endtask

  // cycles an output stays at a level
  task automatic hold_len(input int k, input logic v, output int n);
    wait_for(k, v, 20000);
    n = 0;
    while (sig(k) === v && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) begin
      n_fail++;
      $display("[FAIL] output %0d held %0b beyond %0d cycles", k, v, n);
      give_verdict();
    end
  endtask

  // one burst: health release, phase lengths, span, following gap
  task automatic sc_burst(input logic trig, input int gap);
    int n1, n2, n3, g;
    @(posedge clk) trigger_pin <= trig;
    wait_for(0, 1'b1, 20000); // let a release already under way finish
    wait_for(0, 1'b0, 20000);
    check("charge during release", 1'b0, charge_active);
    hold_len(0, 1'b0, n1);
    check("release width", touch_pkg::HEALTH_CYC, n1);
    wait_for(2, 1'b1, 3);
    hold_len(2, 1'b1, n1);
    in_range("charge phase", CH * 925 / 1000, (CH * 1075 + 999) / 1000, n1);
    hold_len(2, 1'b0, n2);
    in_range("transfer phase", TR * 925 / 1000, (TR * 1075 + 999) / 1000, n2);
    hold_len(1, 1'b1, n3);
    in_range("burst span", BURST, BURST + (CH + TR) * 1075 / 1000 + 2, n1 + n2 + n3);
    wait_for(3, 1'b1, 3);
    check("mode flag", !trig, sleepy_run_mode);
    hold_len(0, 1'b1, g);
    in_range("gap", gap - 3, gap + 3, g);
  endtask

  // one burst with a given result, detect level checked at its end
  task automatic result(input logic hit, input logic exp_det);
    @(posedge clk) burst_over_thresh <= hit;
    wait_for(3, 1'b1, 20000);
    check("detect level", exp_det, detect_out);
    wait_for(3, 1'b0, 3);
  endtask

  task automatic sc_consensus;
    int pc;
    @(posedge clk) trigger_pin <= 1'b1;
    for (int i = 0; i < 3; i++) result(1'b1, 1'b0);
    result(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) result(1'b1, i == 3);
    pc = pulse_count;
    result(1'b1, 1'b1);
    check("pulses while touched", pc, pulse_count);
    result(1'b0, 1'b0);
    pc = pulse_count;
    result(1'b0, 1'b0);
    check("pulses while idle", pc + 1, pulse_count);
    for (int i = 0; i < 4; i++) result(1'b1, i == 3);
    @(posedge clk) max_on_expired <= 1'b1;
    @(posedge clk) max_on_expired <= 1'b0;
    wait_for(4, 1'b0, 3);
    check("detect after expiry", 1'b0, detect_out);
  endtask

  // reset, start-up, then the scenarios
  initial begin
    int n;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("detect during start-up", 1'b0, detect_out);
    hold_len(0, 1'b1, n);
    in_range("start-up", STARTUP - 2, STARTUP + 3, n);
    sc_burst(1'b1, FAST_GAP);
    sc_burst(1'b0, SLEEP_GAP);
    sc_consensus();
    give_verdict();
  end
endmodule // touch_sense_seq_tb_top
